// ### pkg/ianc_cfg.svh
// Register offsets, field positions and reset values of the abort/NACK/DMA block
`ifndef IANC_CFG_SVH
`define IANC_CFG_SVH
`define IANC_OFS_SLV_NACK     8'h84
`define IANC_OFS_DMA_CTRL     8'h88
`define IANC_OFS_DMA_TXWM     8'h8C
`define IANC_OFS_DMA_RXWM     8'h90
`define IANC_OFS_ABORT_CAUSE  8'hA0
`define IANC_OFS_ABORT_CLEAR  8'hA4
`define IANC_OFS_IRQ_STATUS   8'hA8
`define IANC_OFS_IRQ_MASK     8'hAC
`define IANC_BIT_GCALL_READ   5
`define IANC_BIT_GCALL_NOACK  4
`define IANC_BIT_TXDATA_NOACK 3
`define IANC_BIT_WIDE2_NOACK  2
`define IANC_BIT_WIDE1_NOACK  1
`define IANC_BIT_SHORT_NOACK  0
`define IANC_BIT_TX_DMA_EN    1
`define IANC_BIT_RX_DMA_EN    0
`define IANC_BIT_FORCED_NACK  0
`define IANC_RST_SLV_NACK     1'h0
`define IANC_RST_DMA_EN       2'h0
`define IANC_RST_LEVEL        4'h0
`define IANC_RST_CAUSE        6'h00
`define IANC_ABORT_BITS       6
`endif

// ### pkg/ianc_pkg.sv
// Types shared by the abort/NACK/DMA block
package ianc_pkg;
  // Master-side abort events from the protocol engine, one-cycle pulses
  typedef struct packed {
    logic gcall_read;
    logic gcall_noack;
    logic txdata_noack;
    logic wide_addr_second_unacked;
    logic wide_addr_first_unacked;
    logic short_addr_unacked;
  } ianc_abort_ev_t;

  // Role of the controller on the bus
  typedef enum logic [1:0] {
    IANC_ROLE_IDLE,
    IANC_ROLE_MASTER,
    IANC_ROLE_SLV_TX,
    IANC_ROLE_SLV_RX
  } ianc_role_t;

  // Slave-receiver byte decision
  typedef struct packed {
    logic ack;
    logic push;
    logic abort;
  } ianc_rx_dec_t;

  // Avalon-style access state
  typedef enum logic [1:0] {
    IANC_BUS_IDLE,
    IANC_BUS_DONE
  } ianc_bus_st_t;
endpackage

// ### logic/ianc_abort_latch.sv
// Sticky abort-cause latch, set by hardware, cleared by the abort clear
module ianc_abort_latch #(
  parameter int N = 6
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         resetn,
  // Events and clear
  input  wire logic [N-1:0] set_ev,
  input  wire logic         clr,
  // State
  output logic      [N-1:0] cause
);
  // Per bit: a set in the clear cycle survives
  for (genvar i = 0; i < N; i++) begin : g_bit
    always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
        cause[i] <= 1'b0;
      end else if (set_ev[i]) begin
        cause[i] <= 1'b1;
      end else if (clr) begin
        cause[i] <= 1'b0;
      end
    end
  end
endmodule

// ### logic/ianc_ctrl.sv
// Abort causes, slave forced NACK and DMA handshake of the two-wire controller
//
// Overview of operation
// - General call then read command: bit 5
// - Unacknowledged general call sets bit 4
// - Data byte unacknowledged after address: bit 3
// - Wide address second byte unacked: bit 2
// - Wide address first byte unacked: bit 1
// - Short address unacked sets bit 0
// - Forced NACK register only when option set
// - Forced NACK acts only as slave-receiver
// - Forced NACK: nack, abort, discard byte
// - Otherwise acknowledge by normal criteria
// - DMA registers absent without build option
// - Bit 1 transmit, bit 0 receive enable
// - DMA enables writable at any time
// - Transmit request when level at most watermark
// - Receive request when level exceeds watermark
//
// Design decision made here: the Avalon-MM slave port.
`include "ianc_cfg.svh"
module ianc_ctrl #(
  parameter bit SLAVE_FORCED_NACK_OPTION = 1'b1,
  parameter bit DMA_BUILD_OPTION         = 1'b1,
  parameter int FIFO_CNT_W               = 5
) (
  // Clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     resetn,
  // Avalon-MM slave
  input  wire logic [7:0]               avs_address,
  input  wire logic                     avs_read,
  input  wire logic                     avs_write,
  input  wire logic [31:0]              avs_writedata,
  input  wire logic [3:0]               avs_byteenable,
  output logic      [31:0]              avs_readdata,
  output logic                          avs_waitrequest,
  output logic      [1:0]               avs_response,
  // Abort events from the protocol engine
  input  wire ianc_pkg::ianc_abort_ev_t abort_ev,
  // Slave-receiver byte decision
  input  wire ianc_pkg::ianc_role_t     bus_role,
  input  wire logic                     rx_byte_done,
  input  wire logic                     rx_normal_ack,
  output ianc_pkg::ianc_rx_dec_t        rx_dec,
  output logic                          slv_rx_abort,
  // FIFO occupancy
  input  wire logic [FIFO_CNT_W-1:0]    tx_fifo_level,
  input  wire logic [FIFO_CNT_W-1:0]    rx_fifo_level,
  // DMA requests and interrupt
  output logic                          dma_tx_req,
  output logic                          dma_rx_req,
  output logic                          tx_abort_irq
);
  localparam int NA = `IANC_ABORT_BITS;

  logic [NA-1:0] cause;
  logic          forced_nack_r;
  logic [1:0]    dma_en_r;
  logic [3:0]    tx_wm_r;
  logic [3:0]    rx_wm_r;
  logic [NA-1:0] irq_stat_r;
  logic [NA-1:0] irq_mask_r;
  logic          acked_r;
  logic [31:0]   rdata_r;
  logic [1:0]    resp_r;
  logic          slv_rx_abort_r;
  ianc_pkg::ianc_rx_dec_t rx_dec_r;
  logic          dma_tx_req_r;
  logic          dma_rx_req_r;
  ianc_pkg::ianc_bus_st_t bus_st_r;

  // Bus decode: answer one cycle after the request is seen
  wire       access    = avs_read | avs_write;
  wire       take      = access & ~acked_r;
  wire       wr_take   = avs_write & take & avs_byteenable[0];
  wire       hit_nack  = avs_address == `IANC_OFS_SLV_NACK;
  wire       hit_dctl  = avs_address == `IANC_OFS_DMA_CTRL;
  wire       hit_txwm  = avs_address == `IANC_OFS_DMA_TXWM;
  wire       hit_rxwm  = avs_address == `IANC_OFS_DMA_RXWM;
  wire       hit_cause = avs_address == `IANC_OFS_ABORT_CAUSE;
  wire       hit_clr   = avs_address == `IANC_OFS_ABORT_CLEAR;
  wire       hit_stat  = avs_address == `IANC_OFS_IRQ_STATUS;
  wire       hit_mask  = avs_address == `IANC_OFS_IRQ_MASK;
  wire       mapped    = hit_nack | hit_dctl | hit_txwm | hit_rxwm |
                         hit_cause | hit_clr | hit_stat | hit_mask;
  // Absent registers silently drop writes
  wire       wr_nack   = wr_take & hit_nack & SLAVE_FORCED_NACK_OPTION;
  wire       wr_dctl   = wr_take & hit_dctl & DMA_BUILD_OPTION;
  wire       wr_txwm   = wr_take & hit_txwm & DMA_BUILD_OPTION;
  wire       wr_rxwm   = wr_take & hit_rxwm & DMA_BUILD_OPTION;
  wire       wr_mask   = wr_take & hit_mask;
  wire       wr_stat   = wr_take & hit_stat;
  // Abort clear is a read of the clear register, as in the controller family
  wire       abort_clr = avs_read & take & hit_clr;

  // Event vector in cause-bit order
  wire [NA-1:0] ev_vec = abort_ev;

  // Sticky causes
  ianc_abort_latch #(
    .N (NA)
  ) u_latch (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .set_ev  (ev_vec),
    .clr     (abort_clr),
    .cause   (cause)
  );

  // Read mux, absent registers read zero
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_nack && SLAVE_FORCED_NACK_OPTION) begin
      rd_mux[`IANC_BIT_FORCED_NACK] = forced_nack_r;
    end else if (hit_dctl && DMA_BUILD_OPTION) begin
      rd_mux[1:0] = dma_en_r;
    end else if (hit_txwm && DMA_BUILD_OPTION) begin
      rd_mux[3:0] = tx_wm_r;
    end else if (hit_rxwm && DMA_BUILD_OPTION) begin
      rd_mux[3:0] = rx_wm_r;
    end else if (hit_cause) begin
      rd_mux[NA-1:0] = cause;
    end else if (hit_clr) begin
      rd_mux[0] = |cause;
    end else if (hit_stat) begin
      rd_mux[NA-1:0] = irq_stat_r;
    end else if (hit_mask) begin
      rd_mux[NA-1:0] = irq_mask_r;
    end
  end

  // Handshake: waitrequest low for one cycle after capture
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      acked_r  <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      resp_r   <= 2'h0;
      bus_st_r <= ianc_pkg::IANC_BUS_IDLE;
    end else begin
      case (bus_st_r)
        ianc_pkg::IANC_BUS_IDLE: begin
          if (take) begin
            acked_r  <= 1'b1;
            rdata_r  <= avs_read ? rd_mux : 32'h0000_0000;
            resp_r   <= mapped ? 2'h0 : 2'h2;     // Slave error on unmapped
            bus_st_r <= ianc_pkg::IANC_BUS_DONE;
          end
        end
        ianc_pkg::IANC_BUS_DONE: begin
          acked_r  <= 1'b0;
          bus_st_r <= ianc_pkg::IANC_BUS_IDLE;
        end
        default: begin
          acked_r  <= 1'b0;
          bus_st_r <= ianc_pkg::IANC_BUS_IDLE;
        end
      endcase
    end
  end

  assign avs_waitrequest = ~acked_r;
  assign avs_readdata    = rdata_r;
  assign avs_response    = resp_r;

  // Control registers; only low byte lane carries fields
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      forced_nack_r <= `IANC_RST_SLV_NACK;
      dma_en_r      <= `IANC_RST_DMA_EN;
      tx_wm_r       <= `IANC_RST_LEVEL;
      rx_wm_r       <= `IANC_RST_LEVEL;
      irq_mask_r    <= `IANC_RST_CAUSE;
    end else begin
      if (wr_nack) begin
        forced_nack_r <= avs_writedata[`IANC_BIT_FORCED_NACK];
      end
      if (wr_dctl) begin
        dma_en_r <= avs_writedata[1:0];
      end
      if (wr_txwm) begin
        tx_wm_r <= avs_writedata[3:0];
      end
      if (wr_rxwm) begin
        rx_wm_r <= avs_writedata[3:0];
      end
      if (wr_mask) begin
        irq_mask_r <= avs_writedata[NA-1:0];
      end
    end
  end

  // Interrupt status: write one to clear, new event wins
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      irq_stat_r <= `IANC_RST_CAUSE;
    end else begin
      irq_stat_r <= ev_vec | (irq_stat_r & ~(wr_stat ? avs_writedata[NA-1:0] : '0));
    end
  end

  assign tx_abort_irq = |(irq_stat_r & irq_mask_r);

  // Slave-receiver decision; other roles never see the forced NACK
  wire slv_rx   = bus_role == ianc_pkg::IANC_ROLE_SLV_RX;
  wire force_nk = forced_nack_r & SLAVE_FORCED_NACK_OPTION & slv_rx;
  ianc_pkg::ianc_rx_dec_t dec_nxt;
  always_comb begin
    dec_nxt = '0;
    if (rx_byte_done && slv_rx) begin
      if (force_nk) begin
        dec_nxt.ack   = 1'b0;
        dec_nxt.push  = 1'b0;
        dec_nxt.abort = 1'b1;
      end else begin
        dec_nxt.ack   = rx_normal_ack;
        dec_nxt.push  = rx_normal_ack;
        dec_nxt.abort = 1'b0;
      end
    end
  end

  // Registered decision, one cycle after byte done
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rx_dec_r       <= '0;
      slv_rx_abort_r <= 1'b0;
    end else begin
      rx_dec_r       <= dec_nxt;
      slv_rx_abort_r <= dec_nxt.abort;
    end
  end

  assign rx_dec       = rx_dec_r;
  assign slv_rx_abort = slv_rx_abort_r;

  // DMA request compares; levels widened to one bit above the FIFO count width
  wire [FIFO_CNT_W:0] tx_wm_w = (FIFO_CNT_W+1)'(tx_wm_r);
  wire [FIFO_CNT_W:0] rx_wm_w = (FIFO_CNT_W+1)'(rx_wm_r) + (FIFO_CNT_W+1)'(1);
  wire tx_req_nxt = DMA_BUILD_OPTION & dma_en_r[`IANC_BIT_TX_DMA_EN] &
                    ({1'b0, tx_fifo_level} <= tx_wm_w);
  wire rx_req_nxt = DMA_BUILD_OPTION & dma_en_r[`IANC_BIT_RX_DMA_EN] &
                    ({1'b0, rx_fifo_level} >= rx_wm_w);

  // Requests registered so they come from flip-flops
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      dma_tx_req_r <= 1'b0;
      dma_rx_req_r <= 1'b0;
    end else begin
      dma_tx_req_r <= tx_req_nxt;
      dma_rx_req_r <= rx_req_nxt;
    end
  end

  assign dma_tx_req = dma_tx_req_r;
  assign dma_rx_req = dma_rx_req_r;
endmodule

// ### tb/ianc_peer.sv
// Stand-in for the protocol engine and FIFOs on the far side
module ianc_peer (
  // Clock
  input  wire logic              sys_clk,
  // Engine events and FIFO levels
  output ianc_pkg::ianc_abort_ev_t abort_ev,
  output ianc_pkg::ianc_role_t   bus_role,
  output logic                   rx_byte_done,
  output logic                   rx_normal_ack,
  output logic [4:0]             tx_fifo_level,
  output logic [4:0]             rx_fifo_level
);
  timeunit 1ns;
  timeprecision 1ps;
  // Quiet bus, empty FIFOs at start
  initial begin
    abort_ev = '0;
    bus_role = ianc_pkg::IANC_ROLE_IDLE;
    rx_byte_done = 1'b0;
    rx_normal_ack = 1'b0;
    tx_fifo_level = '0;
    rx_fifo_level = '0;
  end
  // One-cycle abort pulse on cause bit i
  task automatic abort(input int i);
    @(posedge sys_clk);
    abort_ev <= 6'(6'h01 << i);
    @(posedge sys_clk);
    abort_ev <= '0;
  endtask
  // One received byte; role is left standing as a real engine would
  task automatic rx_byte(input ianc_pkg::ianc_role_t r, input logic a);
    @(posedge sys_clk);
    bus_role <= r;
    rx_normal_ack <= a;
    rx_byte_done <= 1'b1;
    @(posedge sys_clk);
    rx_byte_done <= 1'b0;
  endtask
  // New FIFO occupancy
  task automatic lvl(input logic [4:0] t, input logic [4:0] r);
    @(posedge sys_clk);
    tx_fifo_level <= t;
    rx_fifo_level <= r;
  endtask
endmodule

// ### tb/ianc_chk.sv
// Port-level assertions for the abort/NACK/DMA controller
module ianc_chk #(
  parameter int FIFO_CNT_W = 5
) (
  // Clock and reset
  input wire logic                     sys_clk,
  input wire logic                     resetn,
  // Register bus
  input wire logic                     avs_read,
  input wire logic                     avs_write,
  input wire logic                     avs_waitrequest,
  // Engine side
  input wire ianc_pkg::ianc_abort_ev_t abort_ev,
  input wire ianc_pkg::ianc_role_t     bus_role,
  input wire logic                     rx_byte_done,
  input wire logic                     rx_normal_ack,
  input wire ianc_pkg::ianc_rx_dec_t   rx_dec,
  input wire logic                     slv_rx_abort,
  input wire logic [FIFO_CNT_W-1:0]    tx_fifo_level,
  input wire logic [FIFO_CNT_W-1:0]    rx_fifo_level,
  input wire logic                     dma_tx_req,
  input wire logic                     dma_rx_req,
  input wire logic                     tx_abort_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // Byte arrivals split by role
  sequence slv_byte;
    rx_byte_done && bus_role == ianc_pkg::IANC_ROLE_SLV_RX;
  endsequence
  sequence other_byte;
    rx_byte_done && bus_role != ianc_pkg::IANC_ROLE_SLV_RX;
  endsequence
  wait_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=>
    !avs_waitrequest) else $error("bus answer late");
  wait_single_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer longer than one cycle");
  role_gate_a: assert property (other_byte |=> rx_dec == '0)
    else $error("byte decision outside slave receive");
  dec_cause_a: assert property (rx_dec != '0 |-> $past(rx_byte_done) &&
    $past(bus_role) == ianc_pkg::IANC_ROLE_SLV_RX) else $error("decision without byte");
  forced_shape_a: assert property (slv_byte ##1 rx_dec.abort |->
    !rx_dec.ack && !rx_dec.push && slv_rx_abort) else $error("forced nack shape wrong");
  normal_ack_a: assert property (rx_dec.push |-> rx_dec.ack && $past(rx_normal_ack))
    else $error("push without normal ack");
  tx_level_a: assert property (dma_tx_req |-> $past(tx_fifo_level) <= 15)
    else $error("tx request above any watermark");
  rx_level_a: assert property (dma_rx_req |-> $past(rx_fifo_level) >= 1)
    else $error("rx request on empty fifo");
  irq_cause_a: assert property ($rose(tx_abort_irq) |->
    $past(abort_ev) != '0 || $past(avs_write)) else $error("interrupt without cause");
endmodule

bind ianc_ctrl ianc_chk #(.FIFO_CNT_W(FIFO_CNT_W)) chk (.sys_clk, .resetn, .avs_read,
  .avs_write, .avs_waitrequest, .abort_ev, .bus_role, .rx_byte_done, .rx_normal_ack,
  .rx_dec, .slv_rx_abort, .tx_fifo_level, .rx_fifo_level, .dma_tx_req, .dma_rx_req,
  .tx_abort_irq);

// ### tb/test_ianc_ctrl.sv
// Self-checking bench for the abort/NACK/DMA controller
module test_ianc_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, resetn, avs_read, avs_write, avs_waitrequest;
  logic [7:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [3:0]  avs_byteenable;
  logic [1:0]  avs_response;
  logic dma_tx_req, dma_rx_req, tx_abort_irq, slv_rx_abort, rx_byte_done, rx_normal_ack;
  ianc_pkg::ianc_abort_ev_t abort_ev;
  ianc_pkg::ianc_role_t     bus_role;
  ianc_pkg::ianc_rx_dec_t   rx_dec;
  logic [4:0] tx_fifo_level, rx_fifo_level;
  int error_cnt, num_checks, cyc;
  // Outputs of the build without the optional registers
  logic [31:0] rdata_bare;
  logic tx_req_bare, rx_req_bare, slv_abort_bare;
  ianc_pkg::ianc_rx_dec_t rx_dec_bare;
  ianc_ctrl dut (.sys_clk, .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .avs_response, .abort_ev, .bus_role,
    .rx_byte_done, .rx_normal_ack, .rx_dec, .slv_rx_abort, .tx_fifo_level, .rx_fifo_level,
    .dma_tx_req, .dma_rx_req, .tx_abort_irq);
  // Same stimulus into a build with both options off
  ianc_ctrl #(.SLAVE_FORCED_NACK_OPTION(1'b0), .DMA_BUILD_OPTION(1'b0)) dut_bare (.sys_clk,
    .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata(rdata_bare), .avs_waitrequest(), .avs_response(), .abort_ev, .bus_role,
    .rx_byte_done, .rx_normal_ack, .rx_dec(rx_dec_bare), .slv_rx_abort(slv_abort_bare),
    .tx_fifo_level, .rx_fifo_level, .dma_tx_req(tx_req_bare), .dma_rx_req(rx_req_bare),
    .tx_abort_irq());
  ianc_peer peer (.sys_clk, .abort_ev, .bus_role, .rx_byte_done, .rx_normal_ack,
    .tx_fifo_level, .rx_fifo_level);
  // 125 MHz clock
  always #4 sys_clk = ~sys_clk;
  // Hang guard, well above the fewer than two hundred cycles needed
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      print_verdict();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One access; held until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  task automatic print_verdict();
    if (error_cnt == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Reset values, read/write, unmapped response
  task automatic reg_defaults();
    rd(8'h84, 32'h0);
    rd(8'h88, 32'h0);
    rd(8'h8C, 32'h0);
    rd(8'hA0, 32'h0);
    bus(1'b1, 8'h8C, 32'h0000000F);
    rd(8'h8C, 32'h0000000F);
    rd(8'h7C, 32'h0);
    chk(32'(avs_response), 32'h2);
  endtask
  // Each cause bit: set, sticky against writes, cleared by the clear read
  task automatic abort_causes();
    for (int i = 0; i < 6; i++) begin
      peer.abort(i);
      bus(1'b1, 8'hA0, 32'h0);
      rd(8'hA0, 32'h1 << i);
      rd(8'hA4, 32'h1);
      rd(8'hA0, 32'h0);
    end
  endtask
  // Interrupt raised, cleared by one, held off by mask
  task automatic irq_path();
    // Earlier scenarios leave status bits standing; start from a clean status
    bus(1'b1, 8'hA8, 32'h0000003F);
    bus(1'b1, 8'hAC, 32'h0000003F);
    chk(32'(tx_abort_irq), 32'h0);
    peer.abort(3);
    // Status is launched at the edge the task returns on; look one edge later
    @(posedge sys_clk);
    chk(32'(tx_abort_irq), 32'h1);
    bus(1'b1, 8'hA8, 32'h00000008);
    chk(32'(tx_abort_irq), 32'h0);
    bus(1'b1, 8'hAC, 32'h0);
    peer.abort(0);
    @(posedge sys_clk);
    chk(32'(tx_abort_irq), 32'h0);
    bus(1'b1, 8'hA8, 32'h0000003F);
  endtask
  // Forced NACK only as slave receiver, normal ack otherwise
  task automatic forced_nack();
    bus(1'b1, 8'h84, 32'h1);
    rd(8'h84, 32'h1);
    chk(rdata_bare, 32'h0);
    peer.rx_byte(ianc_pkg::IANC_ROLE_SLV_RX, 1'b1);
    @(posedge sys_clk);
    chk(32'({rx_dec, slv_rx_abort}), 32'h3);
    chk(32'({rx_dec_bare, slv_abort_bare}), 32'hC);
    peer.rx_byte(ianc_pkg::IANC_ROLE_SLV_TX, 1'b1);
    @(posedge sys_clk);
    chk(32'({rx_dec, slv_rx_abort}), 32'h0);
    bus(1'b1, 8'h84, 32'h0);
    peer.rx_byte(ianc_pkg::IANC_ROLE_SLV_RX, 1'b1);
    @(posedge sys_clk);
    chk(32'({rx_dec, slv_rx_abort}), 32'hC);
    peer.rx_byte(ianc_pkg::IANC_ROLE_SLV_RX, 1'b0);
    @(posedge sys_clk);
    chk(32'({rx_dec, slv_rx_abort}), 32'h0);
  endtask
  // Watermark edges of both requests, enables separate
  task automatic dma_reqs();
    bus(1'b1, 8'h88, 32'h2);
    bus(1'b1, 8'h8C, 32'h4);
    bus(1'b1, 8'h90, 32'h2);
    rd(8'h90, 32'h2);
    chk(rdata_bare, 32'h0);
    peer.lvl(5'h04, 5'h03);
    repeat (2) @(posedge sys_clk);
    chk(32'({dma_tx_req, dma_rx_req}), 32'h2);
    chk(32'({tx_req_bare, rx_req_bare}), 32'h0);
    peer.lvl(5'h05, 5'h03);
    repeat (2) @(posedge sys_clk);
    chk(32'({dma_tx_req, dma_rx_req}), 32'h0);
    bus(1'b1, 8'h88, 32'h1);
    repeat (2) @(posedge sys_clk);
    chk(32'({dma_tx_req, dma_rx_req}), 32'h1);
    chk(32'({tx_req_bare, rx_req_bare}), 32'h0);
    peer.lvl(5'h00, 5'h02);
    repeat (2) @(posedge sys_clk);
    chk(32'({dma_tx_req, dma_rx_req}), 32'h0);
  endtask
  // Main sequence
  initial begin
    sys_clk = 1'b0;
    resetn = 1'b0;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    reg_defaults();
    abort_causes();
    irq_path();
    forced_nack();
    dma_reqs();
    print_verdict();
  end
endmodule
